// [src/rftd_consts.svh]
// Register map, field positions, reset values and codes of the driver bank
// ==========================================================================
// Behaviour
// RULE1: Enable bit drives both pins, else none
// RULE2: Bit 7 inverts second driver pin
// RULE3: Bit 6 inverts first driver pin
// RULE4: Clock mode field; codes 011b, 110b unsupported
// RULE5: Amplitude code picks 100/250/500/1000 mV reduction
// RULE6: Max carrier bit overrides amplitude reduction
// RULE7: Five-bit residual carrier percentage field
// RULE8: Second overshoot length in carrier clocks
// RULE9: Invert bit inverts selected modulation signal
// RULE10: Source select: none, envelope, serial, reserved
// RULE11: First overshoot timer length field
// RULE12: Load current trim steers modulation index
// RULE13: Reserved bits read zero, ignore writes
`ifndef RFTD_CONSTS_SVH
`define RFTD_CONSTS_SVH

// ==========================================================================
// Register offsets
`define RFTD_ADDR_DRIVER_MODE     8'h28
`define RFTD_ADDR_CARRIER_AMP     8'h29
`define RFTD_ADDR_MOD_CONTROL     8'h2A
`define RFTD_ADDR_OVERSHOOT_TRIM  8'h2B
`define RFTD_ADDR_STATUS          8'h30

// ==========================================================================
// Reset values and writable masks
`define RFTD_RST_DRIVER_MODE      8'h00
`define RFTD_RST_CARRIER_AMP      8'h00
`define RFTD_RST_MOD_CONTROL      8'h00
`define RFTD_RST_OVERSHOOT_TRIM   8'h00
`define RFTD_WMASK_DRIVER_MODE    8'hCF
`define RFTD_WMASK_CARRIER_AMP    8'hDF

// ==========================================================================
// Field positions
`define RFTD_DM_TWO_INV           7
`define RFTD_DM_ONE_INV           6
`define RFTD_DM_ENABLE            3
`define RFTD_DM_MODE_HI           2
`define RFTD_AMP_RED_HI           7
`define RFTD_AMP_RED_LO           6
`define RFTD_AMP_RES_HI           4
`define RFTD_CON_LEN_HI           7
`define RFTD_CON_LEN_LO           4
`define RFTD_CON_CW_MAX           3
`define RFTD_CON_INVERT           2
`define RFTD_CON_SEL_HI           1
`define RFTD_TRIM_LEN_HI          7
`define RFTD_TRIM_LEN_LO          4
`define RFTD_TRIM_LOAD_HI         3

// ==========================================================================
// Carrier level reductions in millivolts
`define RFTD_CW_RED0_MV           10'h064
`define RFTD_CW_RED1_MV           10'h0FA
`define RFTD_CW_RED2_MV           10'h1F4
`define RFTD_CW_RED3_MV           10'h3E8
`define RFTD_CW_MAX_MV            10'h000

`endif

// [src/rftd_pkg.sv]
// Types shared by the transmitter driver configuration bank
package rftd_pkg;

   // ======================================================================
   // Driver clock modes
   typedef enum logic [2:0] {
      RFTD_CM_HIZ        = 3'h0,
      RFTD_CM_PUSH_PULL  = 3'h1,
      RFTD_CM_OPEN_DRAIN = 3'h2,
      RFTD_CM_FIX_LOW    = 3'h4,
      RFTD_CM_FIX_HIGH   = 3'h5
   } rftd_clk_mode_t;

   // Modulation sources
   typedef enum logic [1:0] {
      RFTD_SRC_NONE     = 2'h0,
      RFTD_SRC_ENVELOPE = 2'h1,
      RFTD_SRC_SERIAL   = 2'h2
   } rftd_mod_src_t;

   // Overshoot sequencer states, one-hot
   typedef enum logic [3:0] {
      RFTD_ST_IDLE  = 4'h1,
      RFTD_ST_BOOST = 4'h2,
      RFTD_ST_MOD   = 4'h4,
      RFTD_ST_TAIL  = 4'h8
   } rftd_fsm_t;

   // ======================================================================
   // Carriers
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rftd_bus_req_t;

   typedef struct packed {
      logic       enable;
      logic       invert;
      logic [2:0] mode;
   } rftd_drv_cfg_t;

   typedef struct packed {
      logic out;
      logic oe_n;
   } rftd_pin_t;

   // State of the bank, apart from the two driver pin registers
   typedef struct packed {
      logic [7:0] drv_mode;
      logic [7:0] amp;
      logic [7:0] con;
      logic [7:0] trim;
      logic [7:0] rdata;
      logic [2:0] carr_sync;
      logic       carr_lvl;
      logic [2:0] ser_sync;
      logic       ser_lvl;
      rftd_fsm_t  state;
      logic [3:0] cnt;
      logic [9:0] red_mv;
      logic       modulating;
      logic       boost;
   } rftd_state_t;

endpackage

// [src/rftd_driver_pin.sv]
// Output stage of one transmitter driver pin
`timescale 1ns/1ps
`default_nettype none

module rftd_driver_pin (
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    resetn_i,
   // Configuration and drive level
   input  wire rftd_pkg::rftd_drv_cfg_t cfg_i,
   input  wire logic                    data_i,
   // Pin state
   output var  rftd_pkg::rftd_pin_t     pin_o
);

   rftd_pkg::rftd_pin_t d;
   logic                lvl;

   // Mode decode; unsupported codes leave the pin floating
   always_comb begin
      lvl = data_i ^ cfg_i.invert;
      d = '{out: 1'b0, oe_n: 1'b1};
      if (cfg_i.enable) begin // RULE1
         case (cfg_i.mode) // RULE4
            rftd_pkg::RFTD_CM_PUSH_PULL:  d = '{out: lvl, oe_n: 1'b0};
            rftd_pkg::RFTD_CM_OPEN_DRAIN: d = '{out: 1'b0, oe_n: lvl};
            rftd_pkg::RFTD_CM_FIX_LOW:    d = '{out: 1'b0, oe_n: 1'b0};
            rftd_pkg::RFTD_CM_FIX_HIGH:   d = '{out: 1'b1, oe_n: 1'b0};
            default:                      d = '{out: 1'b0, oe_n: 1'b1};
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_o <= '{out: 1'b0, oe_n: 1'b1};
      end else begin
         pin_o <= d;
      end
   end

   // ======================================================================
   // Checks
   pin_disabled_a: assert property ( // RULE1
      @(posedge clk_i) disable iff (!resetn_i)
      !cfg_i.enable |=> pin_o.oe_n && !pin_o.out)
      else $error("Driver pin driven while disabled");

   open_drain_a: assert property ( // RULE4
      @(posedge clk_i) disable iff (!resetn_i)
      cfg_i.enable && cfg_i.mode == rftd_pkg::RFTD_CM_OPEN_DRAIN
      |=> !pin_o.out && (pin_o.oe_n == ($past(data_i) ^ $past(cfg_i.invert))))
      else $error("Open drain pin drove high or missed low");

endmodule // rftd_driver_pin

`default_nettype wire

// [src/rftd_top.sv]
// Transmitter driver configuration bank with overshoot sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rftd_consts.svh"

module rftd_top (
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    resetn_i,
   // Register port
   input  wire rftd_pkg::rftd_bus_req_t bus_i,
   output logic [7:0]                   rdata_o,
   // Modulation and carrier inputs
   input  wire logic                    carrier_i,
   input  wire logic                    transmit_envelope_i,
   input  wire logic                    external_serial_input_i,
   // Driver pins
   output logic                         driver_out_one_o,
   output logic                         driver_out_one_oe_n_o,
   output logic                         driver_out_two_o,
   output logic                         driver_out_two_oe_n_o,
   // Analog controls
   output logic                         cw_max_o,
   output logic [1:0]                   carrier_level_reduction_o,
   output logic [9:0]                   reduction_mv_o,
   output logic [4:0]                   residual_carrier_o,
   output logic [3:0]                   load_current_trim_o,
   // Modulation status
   output logic                         modulating_o,
   output logic                         overshoot_first_o
);

   // ======================================================================
   // State and reset value
   localparam rftd_pkg::rftd_state_t RST = '{
      drv_mode: `RFTD_RST_DRIVER_MODE,
      amp:      `RFTD_RST_CARRIER_AMP,
      con:      `RFTD_RST_MOD_CONTROL,
      trim:     `RFTD_RST_OVERSHOOT_TRIM,
      state:    rftd_pkg::RFTD_ST_IDLE,
      red_mv:   `RFTD_CW_RED0_MV,
      default:  '0
   };

   rftd_pkg::rftd_state_t q;
   rftd_pkg::rftd_state_t d;

   // Decoded fields
   logic [2:0]               driver_clock_mode;
   logic                     drivers_enable;
   logic                     driver_one_invert;
   logic                     driver_two_invert;
   logic [1:0]               carrier_level_reduction;
   logic [1:0]               modulation_source_select;
   logic                     modulation_invert;
   logic [3:0]               overshoot_len_second;
   logic [3:0]               overshoot_len_first;
   logic                     carrier_tick;
   logic                     mod_src;
   logic                     mod_raw;
   logic                     pin_data;
   rftd_pkg::rftd_drv_cfg_t  cfg_one;
   rftd_pkg::rftd_drv_cfg_t  cfg_two;
   rftd_pkg::rftd_pin_t      pin_one;
   rftd_pkg::rftd_pin_t      pin_two;

   // ======================================================================
   // Field decode
   assign driver_clock_mode        = q.drv_mode[`RFTD_DM_MODE_HI:0];
   assign drivers_enable           = q.drv_mode[`RFTD_DM_ENABLE];
   assign driver_one_invert        = q.drv_mode[`RFTD_DM_ONE_INV];
   assign driver_two_invert        = q.drv_mode[`RFTD_DM_TWO_INV];
   assign carrier_level_reduction  = q.amp[`RFTD_AMP_RED_HI:`RFTD_AMP_RED_LO];
   assign modulation_source_select = q.con[`RFTD_CON_SEL_HI:0];
   assign modulation_invert        = q.con[`RFTD_CON_INVERT];
   assign overshoot_len_second     = q.con[`RFTD_CON_LEN_HI:`RFTD_CON_LEN_LO];
   assign overshoot_len_first      = q.trim[`RFTD_TRIM_LEN_HI:`RFTD_TRIM_LEN_LO];

   // Rising carrier edge once second and third stages agree
   assign carrier_tick = (q.carr_sync[1] == q.carr_sync[2]) && q.carr_sync[2] && !q.carr_lvl;

   // Modulation source select and inversion
   always_comb begin
      case (modulation_source_select) // RULE10
         rftd_pkg::RFTD_SRC_ENVELOPE: mod_src = transmit_envelope_i;
         rftd_pkg::RFTD_SRC_SERIAL:   mod_src = q.ser_lvl;
         default:                     mod_src = 1'b0;
      endcase
   end
   assign mod_raw = mod_src ^ modulation_invert; // RULE9

   // Carrier gated off at full modulation depth
   assign pin_data = q.carr_lvl & ~(q.modulating & (q.amp[`RFTD_AMP_RES_HI:0] == 5'h00)); // RULE7

   // Per-pin configuration
   assign cfg_one = '{enable: drivers_enable, invert: driver_one_invert,
                      mode: driver_clock_mode}; // RULE1 RULE3
   assign cfg_two = '{enable: drivers_enable, invert: driver_two_invert,
                      mode: driver_clock_mode}; // RULE1 RULE2

   // ======================================================================
   // Next state
   always_comb begin
      d = q;
      // Pin synchronisers
      d.carr_sync = {q.carr_sync[1:0], carrier_i};
      d.ser_sync  = {q.ser_sync[1:0], external_serial_input_i};
      if (q.carr_sync[1] == q.carr_sync[2]) begin
         d.carr_lvl = q.carr_sync[2];
      end
      if (q.ser_sync[1] == q.ser_sync[2]) begin
         d.ser_lvl = q.ser_sync[2];
      end

      // Register writes, reserved bits held at zero
      if (bus_i.wr) begin
         case (bus_i.addr)
            `RFTD_ADDR_DRIVER_MODE:
               d.drv_mode = bus_i.wdata & `RFTD_WMASK_DRIVER_MODE; // RULE13
            `RFTD_ADDR_CARRIER_AMP:
               d.amp = bus_i.wdata & `RFTD_WMASK_CARRIER_AMP; // RULE13
            `RFTD_ADDR_MOD_CONTROL:    d.con = bus_i.wdata;
            `RFTD_ADDR_OVERSHOOT_TRIM: d.trim = bus_i.wdata; // RULE12
            default:                   d.rdata = q.rdata;
         endcase
      end

      // Register reads, answered in the next cycle only
      d.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            `RFTD_ADDR_DRIVER_MODE:    d.rdata = q.drv_mode;
            `RFTD_ADDR_CARRIER_AMP:    d.rdata = q.amp;
            `RFTD_ADDR_MOD_CONTROL:    d.rdata = q.con;
            `RFTD_ADDR_OVERSHOOT_TRIM: d.rdata = q.trim;
            `RFTD_ADDR_STATUS:
               d.rdata = {q.state, q.carr_lvl, q.ser_lvl, q.modulating, q.boost};
            default:                   d.rdata = 8'h00;
         endcase
      end

      // Carrier amplitude reduction, maximum override first
      if (q.con[`RFTD_CON_CW_MAX]) begin // RULE6
         d.red_mv = `RFTD_CW_MAX_MV;
      end else begin
         case (carrier_level_reduction) // RULE5
            2'h0:    d.red_mv = `RFTD_CW_RED0_MV;
            2'h1:    d.red_mv = `RFTD_CW_RED1_MV;
            2'h2:    d.red_mv = `RFTD_CW_RED2_MV;
            default: d.red_mv = `RFTD_CW_RED3_MV;
         endcase
      end

      // Overshoot sequencer
      case (q.state)
         rftd_pkg::RFTD_ST_IDLE: begin
            if (mod_raw && overshoot_len_first != 4'h0) begin // RULE11
               d.state = rftd_pkg::RFTD_ST_BOOST;
               d.cnt   = overshoot_len_first;
            end else if (mod_raw) begin
               d.state = rftd_pkg::RFTD_ST_MOD;
            end
         end
         rftd_pkg::RFTD_ST_BOOST: begin
            if (carrier_tick && q.cnt == 4'h1) begin // RULE11
               d.state = rftd_pkg::RFTD_ST_MOD;
               d.cnt   = 4'h0;
            end else if (carrier_tick) begin
               d.cnt = q.cnt - 4'h1;
            end
         end
         rftd_pkg::RFTD_ST_MOD: begin
            if (!mod_raw && overshoot_len_second != 4'h0) begin // RULE8
               d.state = rftd_pkg::RFTD_ST_TAIL;
               d.cnt   = overshoot_len_second;
            end else if (!mod_raw) begin
               d.state = rftd_pkg::RFTD_ST_IDLE;
            end
         end
         rftd_pkg::RFTD_ST_TAIL: begin
            if (mod_raw) begin
               d.state = rftd_pkg::RFTD_ST_MOD;
               d.cnt   = 4'h0;
            end else if (carrier_tick && q.cnt == 4'h1) begin // RULE8
               d.state = rftd_pkg::RFTD_ST_IDLE;
               d.cnt   = 4'h0;
            end else if (carrier_tick) begin
               d.cnt = q.cnt - 4'h1;
            end
         end
         default: begin
            d.state = rftd_pkg::RFTD_ST_IDLE;
            d.cnt   = 4'h0;
         end
      endcase
      d.modulating = (d.state != rftd_pkg::RFTD_ST_IDLE);
      d.boost      = (d.state == rftd_pkg::RFTD_ST_BOOST);
   end

   // State register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   // ======================================================================
   // Driver pins
   rftd_driver_pin u_pin_one (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .cfg_i    (cfg_one),
      .data_i   (pin_data),
      .pin_o    (pin_one)
   );

   rftd_driver_pin u_pin_two (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .cfg_i    (cfg_two),
      .data_i   (pin_data),
      .pin_o    (pin_two)
   );

   // ======================================================================
   // Outputs, all from flip-flops
   assign rdata_o                   = q.rdata;
   assign driver_out_one_o          = pin_one.out;
   assign driver_out_one_oe_n_o     = pin_one.oe_n;
   assign driver_out_two_o          = pin_two.out;
   assign driver_out_two_oe_n_o     = pin_two.oe_n;
   assign cw_max_o                  = q.con[`RFTD_CON_CW_MAX]; // RULE6
   assign carrier_level_reduction_o = carrier_level_reduction;
   assign reduction_mv_o            = q.red_mv;
   assign residual_carrier_o        = q.amp[`RFTD_AMP_RES_HI:0]; // RULE7
   assign load_current_trim_o       = q.trim[`RFTD_TRIM_LOAD_HI:0]; // RULE12
   assign modulating_o              = q.modulating;
   assign overshoot_first_o         = q.boost;

   // ======================================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   pins_enable_a: assert property ( // RULE1
      drivers_enable && driver_clock_mode == rftd_pkg::RFTD_CM_FIX_LOW
      |=> !driver_out_one_oe_n_o && !driver_out_two_oe_n_o)
      else $error("Enabled drivers not both driving");

   pins_off_a: assert property ( // RULE1
      !drivers_enable |=> driver_out_one_oe_n_o && driver_out_two_oe_n_o)
      else $error("Disabled drivers still driving");

   two_invert_a: assert property ( // RULE2
      drivers_enable && driver_clock_mode == rftd_pkg::RFTD_CM_PUSH_PULL
      |=> driver_out_two_o == ($past(pin_data) ^ $past(driver_two_invert)))
      else $error("Second pin level wrong");

   one_invert_a: assert property ( // RULE3
      drivers_enable && driver_clock_mode == rftd_pkg::RFTD_CM_PUSH_PULL
      |=> driver_out_one_o == ($past(pin_data) ^ $past(driver_one_invert)))
      else $error("First pin level wrong");

   bad_mode_a: assert property ( // RULE4
      driver_clock_mode == 3'h3 || driver_clock_mode == 3'h6
      |=> driver_out_one_oe_n_o && driver_out_two_oe_n_o)
      else $error("Unsupported mode drove a pin");

   reduce_mv_a: assert property ( // RULE5
      !q.con[`RFTD_CON_CW_MAX] && carrier_level_reduction == 2'h3
      |=> reduction_mv_o == `RFTD_CW_RED3_MV)
      else $error("Largest reduction not applied");

   cw_max_a: assert property ( // RULE6
      cw_max_o |=> reduction_mv_o == `RFTD_CW_MAX_MV)
      else $error("Maximum carrier did not override reduction");

   resid_write_a: assert property ( // RULE7
      bus_i.wr && bus_i.addr == `RFTD_ADDR_CARRIER_AMP
      |=> residual_carrier_o == $past(bus_i.wdata[4:0]))
      else $error("Residual carrier not updated");

   tail_load_a: assert property ( // RULE8
      q.state == rftd_pkg::RFTD_ST_MOD && !mod_raw && overshoot_len_second != 4'h0
      |=> q.state == rftd_pkg::RFTD_ST_TAIL && q.cnt == $past(overshoot_len_second))
      else $error("Second overshoot length not loaded");

   tail_end_a: assert property ( // RULE8
      q.state == rftd_pkg::RFTD_ST_TAIL && !mod_raw && carrier_tick && q.cnt == 4'h1
      |=> q.state == rftd_pkg::RFTD_ST_IDLE && !modulating_o)
      else $error("Second overshoot did not end on count");

   inv_none_a: assert property ( // RULE9
      q.state == rftd_pkg::RFTD_ST_IDLE && modulation_invert
      && modulation_source_select == 2'h0 |=> ##1 modulating_o)
      else $error("Inverted idle source did not modulate");

   env_src_a: assert property ( // RULE10
      q.state == rftd_pkg::RFTD_ST_IDLE && !modulation_invert && transmit_envelope_i
      && modulation_source_select == 2'h1 |=> q.state != rftd_pkg::RFTD_ST_IDLE)
      else $error("Envelope source ignored");

   boost_load_a: assert property ( // RULE11
      q.state == rftd_pkg::RFTD_ST_IDLE && mod_raw && overshoot_len_first != 4'h0
      |=> overshoot_first_o && q.cnt == $past(overshoot_len_first))
      else $error("First overshoot length not loaded");

   trim_write_a: assert property ( // RULE12
      bus_i.wr && bus_i.addr == `RFTD_ADDR_OVERSHOOT_TRIM
      |=> load_current_trim_o == $past(bus_i.wdata[3:0]))
      else $error("Load trim not updated");

   rsvd_read_a: assert property ( // RULE13
      bus_i.rd && (bus_i.addr == `RFTD_ADDR_DRIVER_MODE
      || bus_i.addr == `RFTD_ADDR_CARRIER_AMP)
      |=> rdata_o[5] == 1'b0 && (rdata_o[4] == 1'b0 || $past(bus_i.addr[0])))
      else $error("Reserved bits read nonzero");

   // Main scenarios
   boost_seen_c: cover property (q.state == rftd_pkg::RFTD_ST_BOOST ##1
      q.state == rftd_pkg::RFTD_ST_MOD);
   tail_seen_c: cover property (q.state == rftd_pkg::RFTD_ST_TAIL ##1
      q.state == rftd_pkg::RFTD_ST_IDLE);
   od_mode_c: cover property (drivers_enable
      && driver_clock_mode == rftd_pkg::RFTD_CM_OPEN_DRAIN);
   serial_mod_c: cover property (modulation_source_select == 2'h2 && modulating_o);

endmodule // rftd_top

`default_nettype wire

// [test/rftd_antenna_model.sv]
// Antenna matching network model as seen from the two driver pins
`timescale 1ns/1ps
`default_nettype none

module rftd_antenna_model (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic resetn_i,
   // Driver pins
   input  wire logic one_i,
   input  wire logic one_oe_n_i,
   input  wire logic two_i,
   input  wire logic two_oe_n_i,
   // Coil levels
   output logic      one_lvl_o,
   output logic      two_lvl_o
);
   // ======================================================================
   // Coil level; a released pin floats, so a stale copy never shows
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         one_lvl_o <= 1'b0;
         two_lvl_o <= 1'b0;
      end else begin
         one_lvl_o <= one_oe_n_i ? ~one_lvl_o : one_i;
         two_lvl_o <= two_oe_n_i ? ~two_lvl_o : two_i;
      end
   end
endmodule // rftd_antenna_model
`default_nettype wire

// [test/rf_transmitter_driver_config_test.sv]
// Self-checking bench of the transmitter driver configuration bank
`timescale 1ns/1ps
`default_nettype none

module rf_transmitter_driver_config_test;
   logic                    clk_i = 1'b0;
   logic                    resetn_i = 1'b0;
   rftd_pkg::rftd_bus_req_t bus_i = '0;
   logic                    carrier_i, env = 1'b0, ser = 1'b0, run = 1'b0;
   logic [7:0]              rdata_o, v, d, sh[4];
   logic                    o1, oe1, o2, oe2, cwm, modl, boost, l1, l2;
   logic [1:0]              red;
   logic [9:0]              mv;
   logic [4:0]              res;
   logic [3:0]              trim, t1, t2;
   int                      n_fail = 0, checked = 0, cyc = 0, n;
   logic [31:0]             seed = 32'h72A06D17;
   logic [7:0]              msk[4] = '{8'hCF, 8'hDF, 8'hFF, 8'hFF};

   // ======================================================================
   // Clock, carrier with one tick every 8 cycles, run ceiling
   initial forever #2 clk_i = ~clk_i;
   assign carrier_i = run & cyc[2];
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict;
      end
   end

   rftd_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .carrier_i(carrier_i), .transmit_envelope_i(env), .external_serial_input_i(ser),
      .driver_out_one_o(o1), .driver_out_one_oe_n_o(oe1), .driver_out_two_o(o2),
      .driver_out_two_oe_n_o(oe2), .cw_max_o(cwm), .carrier_level_reduction_o(red),
      .reduction_mv_o(mv), .residual_carrier_o(res), .load_current_trim_o(trim),
      .modulating_o(modl), .overshoot_first_o(boost));
   rftd_antenna_model ant (.clk_i(clk_i), .resetn_i(resetn_i), .one_i(o1),
      .one_oe_n_i(oe1), .two_i(o2), .two_oe_n_i(oe2), .one_lvl_o(l1), .two_lvl_o(l2));

   // ======================================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [9:0] mv_of(input logic [1:0] c, input logic mx);
      if (mx) return 10'h000;
      return (c == 2'h0) ? 10'h064 : (c == 2'h1) ? 10'h0FA : (c == 2'h2) ? 10'h1F4 : 10'h3E8;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      bus_i.addr <= a;
      bus_i.wdata <= wd;
      bus_i.wr <= 1'b1;
      @(posedge clk_i);
      bus_i.wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      bus_i.addr <= a;
      bus_i.rd <= 1'b1;
      @(posedge clk_i);
      bus_i.rd <= 1'b0;
      @(negedge clk_i);
      q = rdata_o;
      @(posedge clk_i);
   endtask
   task automatic fields;
      @(negedge clk_i);
      chk({cwm, red, res, trim}, {sh[2][3], sh[1][7:6], sh[1][4:0], sh[3][3:0]});
      chk(mv, mv_of(sh[1][7:6], sh[2][3]));
      @(posedge clk_i);
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ======================================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      for (int a = 0; a < 4; a++) begin
         sh[a] = 8'h00;
         rd(8'h28 + a[7:0], v);
         chk(v, 8'h00);
      end
      chk({oe1, oe2, modl}, 3'b110);
      rd(8'h31, v);
      chk(v, 8'h00);
      // Status after reset: sequencer idle, pins low
      rd(8'h30, v);
      chk(v, 8'h10);
      // Random writes, read back through the reserved-bit masks
      run <= 1'b1;
      repeat (32) begin
         seed = lfsr(seed);
         d = seed[15:8];
         if (seed[1:0] == 2'h0 && (d[2:0] == 3'h3 || d[2:0] == 3'h6)) d[2:0] = 3'h1;
         wr(8'h28 + seed[1:0], d);
         sh[seed[1:0]] = d & msk[seed[1:0]];
         rd(8'h28 + seed[1:0], v);
         chk(v, sh[seed[1:0]]);
         fields;
      end
      // Every reduction code with and without the maximum override
      for (int c = 0; c < 8; c++) begin
         sh[1] = {c[1:0], 6'h15};
         sh[2] = {4'h0, c[2], 3'h0};
         wr(8'h29, sh[1]);
         wr(8'h2A, sh[2]);
         fields;
      end
      wr(8'h2B, 8'h00);
      wr(8'h2A, 8'h00);
      // Long enough for a leftover second overshoot of 15 ticks to drain
      repeat (140) @(posedge clk_i);
      run <= 1'b0;
      repeat (10) @(posedge clk_i);
      // Pin inversion and enable, carrier held low
      for (int i = 0; i < 4; i++) begin
         wr(8'h28, {i[1:0], 6'h09});
         @(posedge clk_i);
         chk({oe1, o1, oe2, o2}, {1'b0, i[0], 1'b0, i[1]});
         @(posedge clk_i);
         chk({l1, l2}, {i[0], i[1]});
      end
      wr(8'h28, 8'hC1);
      @(posedge clk_i);
      chk({oe1, o1, oe2, o2}, 4'b1010);
      for (int m = 0; m < 3; m++) begin
         wr(8'h28, (m == 0) ? 8'h08 : (m == 1) ? 8'h0C : 8'h0D);
         @(posedge clk_i);
         chk({oe1, o1, oe2, o2}, (m == 0) ? 4'b1010 : (m == 1) ? 4'b0000 : 4'b0101);
      end
      // Open drain: low level drives, inverted high level releases
      wr(8'h28, 8'h0A);
      @(posedge clk_i);
      chk({oe1, o1, oe2, o2}, 4'b0000);
      wr(8'h28, 8'hCA);
      @(posedge clk_i);
      chk({oe1, o1, oe2, o2}, 4'b1010);
      // Every source code with and without inversion, no overshoot
      for (int k = 0; k < 8; k++) begin
         env <= k[0];
         ser <= k[1];
         wr(8'h2A, {5'h00, k[2:0]});
         repeat (8) @(posedge clk_i);
         chk(modl, (k[1:0] == 2'h1 || k[1:0] == 2'h2) ^ k[2]);
      end
      // Overshoot lengths counted in carrier ticks
      run <= 1'b1;
      repeat (4) begin
         seed = lfsr(seed);
         t1 = 4'h1 + seed[1:0];
         t2 = 4'h1 + seed[3:2];
         env <= 1'b0;
         wr(8'h2B, {t1, 4'h0});
         wr(8'h2A, {t2, 4'h1});
         repeat (60) @(posedge clk_i);
         env <= 1'b1;
         n = 0;
         repeat (80) begin
            @(negedge clk_i);
            if (boost === 1'b1) n++;
         end
         chk(n > (t1 - 1) * 8 && n <= t1 * 8, 1);
         @(posedge clk_i);
         env <= 1'b0;
         n = 0;
         repeat (80) begin
            @(negedge clk_i);
            if (modl === 1'b1) n++;
         end
         chk(n > (t2 - 1) * 8 && n <= t2 * 8 + 2, 1);
         @(posedge clk_i);
      end
      print_verdict;
   end
endmodule // rf_transmitter_driver_config_test
`default_nettype wire
